// File: src/drx_consts.svh
// Constants for the serial bus data capture unit
`ifndef DRX_CONSTS_SVH
`define DRX_CONSTS_SVH
// Register byte offsets
`define DRX_DATA_OFS 8'h00
`define DRX_SIZE_OFS 8'h04
`define DRX_STAT_OFS 8'h08
`define DRX_CTRL_OFS 8'h0c
// Status fields
`define DRX_STAT_NEW_BIT 0
`define DRX_STAT_OVR_BIT 1
`define DRX_STAT_BUSY_BIT 2
// Control fields
`define DRX_CTRL_EN_BIT 0
`define DRX_CTRL_RST 1'h1
// Capacity: size code of the largest frame taken (3 = 4 bytes)
`define DRX_CAP_CODE 3'h3
`define DRX_DATA_W 32
// Frame type codes
`define DRX_TYPE_NONE 3'h0
`define DRX_TYPE_CANCEL 3'h7
// Status answer for no sender or oversize
`define DRX_NAK_PAT 3'h5
// AXI responses
`define DRX_RESP_OKAY 2'h0
`define DRX_RESP_SLVERR 2'h2
`endif

// File: src/drx_pkg.sv
// Types for the serial bus data capture unit
package drx_pkg;
  typedef enum logic [3:0] {
    DRX_IDLE = 4'h0,
    DRX_TYPE = 4'h1,
    DRX_DATA = 4'h3,
    DRX_ST2 = 4'h2,
    DRX_ST1 = 4'h6,
    DRX_DRV0 = 4'h7,
    DRX_REL = 4'h5,
    DRX_JAM = 4'h4,
    DRX_COMMIT = 4'hc,
    DRX_NAK = 4'hd
  } drx_state_e;
  typedef logic [8:0] drx_bits_t;
endpackage : drx_pkg

// File: src/drx_data_capture_unit.sv
// Serial bus data capture unit with AXI4-Lite register access
// Behaviour
// - In bus reset, release and ignore line
// - Bus reset clears data and size registers
// - Bus reset release enters idle
// - Idle waits for select and start one
// - Sample three frame type bits, MSB first
// - Decode type: none, sizes, cancelled
// - Cancelled type returns idle, no drive
// - No sender: drive 101, release, idle
// - Oversize: skip data, drive 101, idle
// - Shift data MSB first into holding
// - Holding register kept; strobe-only variant unused
// - Status bit 2 one returns idle
// - Save status bit 1 for decision
// - Drive status bit 0 as present
// - Release line, then sample jam bit
// - Failure leaves outputs unchanged, idle
// - Success copies holding and size out
// - Size output uses frame type encoding
// - Flag overrun of unread data
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "drx_consts.svh"
module drx_data_capture_unit
  import drx_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial bus
  input wire logic system_reset_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_n_i,
  output logic serial_data_line_n_o,
  output logic serial_data_line_n_oe,
  // Header decoder and onboard logic
  input wire logic receive_select,
  output logic [`DRX_DATA_W-1:0] data_out,
  output logic [2:0] size_out,
  output logic commit_pulse
);

  function automatic drx_bits_t drx_bits_of(input logic [2:0] code);
    drx_bits_of = drx_bits_t'(9'h008 << (code - 3'h1));
  endfunction : drx_bits_of

  // Pin synchronisers
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic sclk_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg <= 4'h1;
      pin_s2_reg <= 4'h1;
      sclk_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {receive_select, system_reset_n, serial_clock_line, serial_data_line_n_i};
      pin_s2_reg <= pin_s1_reg;
      sclk_d_reg <= pin_s2_reg[1];
    end
  end

  logic bus_ok;
  logic line_one;
  logic sel_s;
  logic sample_edge;
  logic change_edge;
  assign bus_ok = pin_s2_reg[2];
  assign line_one = ~pin_s2_reg[0];
  assign sel_s = pin_s2_reg[3];
  assign sample_edge = pin_s2_reg[1] & ~sclk_d_reg;
  assign change_edge = ~pin_s2_reg[1] & sclk_d_reg;

  // Control and frame state
  logic ctrl_en_reg;
  drx_state_e state_reg;
  logic [2:0] type_reg;
  drx_bits_t cnt_reg;
  logic skip_reg;
  logic st1_reg;
  logic [1:0] nak_reg;
  logic [`DRX_DATA_W-1:0] hold_reg;
  logic [2:0] type_next;
  assign type_next = {type_reg[1:0], line_one};

  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_ok) begin
      state_reg <= DRX_IDLE;
      type_reg <= 3'h0;
      cnt_reg <= '0;
      skip_reg <= 1'b0;
      st1_reg <= 1'b0;
      nak_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        DRX_IDLE: if (sample_edge && sel_s && ctrl_en_reg && line_one) begin
          state_reg <= DRX_TYPE;
          cnt_reg <= '0;
        end
        DRX_TYPE: if (sample_edge) begin
          type_reg <= type_next;
          cnt_reg <= cnt_reg + 9'h001;
          if (cnt_reg == 9'h002) begin
            cnt_reg <= '0;
            nak_reg <= 2'h0;
            if (type_next == `DRX_TYPE_CANCEL) begin
              state_reg <= DRX_IDLE;
            end else if (type_next == `DRX_TYPE_NONE) begin
              state_reg <= DRX_NAK;
            end else begin
              skip_reg <= type_next > `DRX_CAP_CODE;
              state_reg <= DRX_DATA;
            end
          end
        end
        DRX_DATA: if (sample_edge) begin
          cnt_reg <= cnt_reg + 9'h001;
          if (cnt_reg == drx_bits_of(type_reg) - 9'h001) begin
            state_reg <= skip_reg ? DRX_NAK : DRX_ST2;
          end
        end
        DRX_ST2: if (sample_edge) begin
          state_reg <= line_one ? DRX_IDLE : DRX_ST1;
        end
        DRX_ST1: if (sample_edge) begin
          st1_reg <= line_one;
          state_reg <= DRX_DRV0;
        end
        DRX_DRV0: if (change_edge) begin
          state_reg <= DRX_REL;
        end
        DRX_REL: if (change_edge) begin
          state_reg <= DRX_JAM;
        end
        DRX_JAM: if (sample_edge) begin
          state_reg <= (st1_reg && !line_one) ? DRX_COMMIT : DRX_IDLE;
        end
        DRX_COMMIT: if (change_edge) begin
          state_reg <= DRX_IDLE;
        end
        DRX_NAK: if (change_edge) begin
          nak_reg <= nak_reg + 2'h1;
          if (nak_reg == 2'h3) begin
            state_reg <= DRX_IDLE;
          end
        end
        default: state_reg <= DRX_IDLE;
      endcase
    end
  end

  // Answer bits in change-edge order; the trailing zero is the release
  logic [3:0] nak_seq;
  assign nak_seq = {`DRX_NAK_PAT, 1'b0};

  // Line driver; a one is a low pull, released otherwise
  always_ff @(posedge aclk) begin
    serial_data_line_n_o <= 1'b0;
    if (!aresetn || !bus_ok) begin
      serial_data_line_n_oe <= 1'b0;
    end else if (change_edge) begin
      unique case (state_reg)
        DRX_DRV0: serial_data_line_n_oe <= 1'b1;
        DRX_REL: serial_data_line_n_oe <= 1'b0;
        DRX_NAK: serial_data_line_n_oe <= nak_seq[2'h3 - nak_reg];
        default: serial_data_line_n_oe <= serial_data_line_n_oe;
      endcase
    end
  end

  // Holding register; the output copy happens only on success
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_ok) begin
      hold_reg <= '0;
    end else if (state_reg == DRX_TYPE && sample_edge && cnt_reg == 9'h002) begin
      hold_reg <= '0;
    end else if (state_reg == DRX_DATA && sample_edge && !skip_reg) begin
      hold_reg <= {hold_reg[`DRX_DATA_W-2:0], line_one};
    end
  end

  logic commit;
  assign commit = state_reg == DRX_COMMIT && change_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_ok) begin
      data_out <= '0;
      size_out <= 3'h0;
      commit_pulse <= 1'b0;
    end else begin
      commit_pulse <= commit;
      if (commit) begin
        data_out <= hold_reg;
        size_out <= type_reg;
      end
    end
  end

  // Unread and overrun flags; a new commit wins over a clear
  logic new_reg;
  logic ovr_reg;
  logic data_rd;
  logic ovr_clr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      new_reg <= commit || (new_reg && !data_rd);
      ovr_reg <= (commit && new_reg) || (ovr_reg && !ovr_clr);
    end
  end

  // AXI4-Lite write side
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign ovr_clr = do_write && aw_addr_reg == `DRX_STAT_OFS && w_strb_reg[0] &&
    w_data_reg[`DRX_STAT_OVR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DRX_RESP_OKAY;
      ctrl_en_reg <= `DRX_CTRL_RST;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DRX_RESP_OKAY;
        if (aw_addr_reg == `DRX_CTRL_OFS) begin
          if (w_strb_reg[0]) begin
            ctrl_en_reg <= w_data_reg[`DRX_CTRL_EN_BIT];
          end
        end else if (aw_addr_reg != `DRX_STAT_OFS) begin
          s_axi_bresp <= `DRX_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  assign data_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == `DRX_DATA_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DRX_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DRX_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      unique case (s_axi_araddr)
        `DRX_DATA_OFS: s_axi_rdata <= data_out;
        `DRX_SIZE_OFS: s_axi_rdata <= {29'h0, size_out};
        `DRX_STAT_OFS: s_axi_rdata <= {29'h0, state_reg != DRX_IDLE, ovr_reg, new_reg};
        `DRX_CTRL_OFS: s_axi_rdata <= {31'h0, ctrl_en_reg};
        default: s_axi_rresp <= `DRX_RESP_SLVERR;
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rel_in_reset_a: assert property (!bus_ok |=> !serial_data_line_n_oe)
    else $error("line driven during bus reset");
  clr_in_reset_a: assert property (!bus_ok |=> data_out == '0 && size_out == 3'h0)
    else $error("outputs not cleared in bus reset");
  idle_after_reset_a: assert property (!bus_ok ##1 bus_ok |-> state_reg == DRX_IDLE)
    else $error("not idle after bus reset");
  leave_idle_a: assert property (
    bus_ok && state_reg == DRX_IDLE && sample_edge && sel_s && ctrl_en_reg && line_one
    |=> state_reg == DRX_TYPE)
    else $error("start of frame missed");
  cancel_idle_a: assert property (
    bus_ok && state_reg == DRX_TYPE && sample_edge && cnt_reg == 9'h002 && type_next == 3'h7
    |=> (state_reg == DRX_IDLE && !serial_data_line_n_oe) [*2])
    else $error("cancelled frame not dropped");
  size_route_a: assert property (
    bus_ok && state_reg == DRX_TYPE && sample_edge && cnt_reg == 9'h002 &&
    type_next != 3'h0 && type_next != 3'h7
    |=> state_reg == DRX_DATA && skip_reg == (type_reg > `DRX_CAP_CODE))
    else $error("frame type routed wrongly");
  nak_drive_a: assert property (
    bus_ok && state_reg == DRX_NAK && change_edge && nak_reg == 2'h1
    |=> !serial_data_line_n_oe)
    else $error("middle status bit not released");
  over_skip_a: assert property (
    bus_ok && state_reg == DRX_DATA && skip_reg && sample_edge
    |=> $stable(hold_reg))
    else $error("oversize data stored");
  status_two_a: assert property (
    bus_ok && state_reg == DRX_ST2 && sample_edge && line_one
    |=> state_reg == DRX_IDLE)
    else $error("status bit 2 ignored");
  present_drive_a: assert property (
    bus_ok && state_reg == DRX_DRV0 && change_edge
    |=> serial_data_line_n_oe && state_reg == DRX_REL)
    else $error("presence bit not driven");
  rel_line_a: assert property (
    bus_ok && state_reg == DRX_REL && change_edge
    |=> !serial_data_line_n_oe && state_reg == DRX_JAM)
    else $error("line not released before jam bit");
  fail_keep_a: assert property (
    bus_ok && state_reg == DRX_JAM && sample_edge && (!st1_reg || line_one)
    |=> state_reg == DRX_IDLE && $stable(data_out))
    else $error("failed frame changed output");
  commit_copy_a: assert property (
    bus_ok && commit
    |=> data_out == $past(hold_reg) && size_out == $past(type_reg) && commit_pulse)
    else $error("commit copied wrong data");
  ovr_set_a: assert property (commit && new_reg |=> ovr_reg)
    else $error("overrun not flagged");
  // Pull only during the presence bit or the refusal answer
  wired_or_a: assert property (
    serial_data_line_n_oe |-> !serial_data_line_n_o &&
    (state_reg == DRX_REL || state_reg == DRX_NAK))
    else $error("line driven outside a status answer");

  good_frame_c: cover property (commit);
  nak_frame_c: cover property (state_reg == DRX_NAK && nak_reg == 2'h3 && change_edge);
  overrun_c: cover property (commit && new_reg);
  skip_frame_c: cover property (state_reg == DRX_DATA && skip_reg && sample_edge);

endmodule : drx_data_capture_unit

// File: verif/drx_sender_model.sv
// Far-side model: drives the serial clock and pulls the data line
`timescale 1ns/10ps
module drx_sender_model (
  // Clock
  input wire logic aclk,
  // Serial bus
  input wire logic line_n,
  output logic sclk,
  output logic pull
);
  initial begin
    sclk = 1'b0;
    pull = 1'b0;
  end
  // Bit placed just after the fall, read back just before the next fall
  task slot(input logic b, output logic seen);
    @(posedge aclk);
    pull <= b;
    repeat (3) @(posedge aclk);
    sclk <= 1'b1;
    repeat (4) @(posedge aclk);
    seen = ~line_n;
    sclk <= 1'b0;
  endtask : slot
  // Clock stands still between frames; drv is st2, st1, bit0, jam
  task frame(input logic [2:0] code, input logic [31:0] d, input logic [3:0] drv,
             output logic [2:0] st);
    logic s;
    int n;
    n = (code >= 3'h1 && code <= 3'h6) ? (8 << (code - 3'h1)) : 0;
    slot(1'b1, s);
    for (int i = 2; i >= 0; i--) begin
      slot(code[i], s);
    end
    for (int i = n - 1; i >= 0; i--) begin
      slot((i < 32) ? d[i] : 1'b0, s);
    end
    for (int i = 3; i >= 1; i--) begin
      slot(drv[i], s);
      st[i-1] = s;
    end
    slot(drv[0], s);
    @(posedge aclk);
    pull <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : frame
endmodule : drx_sender_model

// File: verif/tb_top.sv
// Self-checking bench for the serial bus data capture unit
`timescale 1ns/10ps
`include "drx_consts.svh"
module tb_top;
  typedef struct packed {
    logic [2:0] code;
    logic [31:0] data;
    logic [3:0] drv;
    logic [2:0] st;
    logic ok;
  } drx_row_s;
  logic aclk, aresetn, sys_rst_n, sel, sclk, pull, oe, line_o, pulse;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, dout, exp_d, v;
  logic [1:0] bresp, rresp, r;
  logic [2:0] sout, exp_sz, st;
  int n_fail, compares, cyc, pulses;
  drx_row_s rows [12];
  // Wired-OR line with pull-up: low when anyone pulls
  wire logic line_n = (oe ? line_o : 1'b1) & ~pull;
  drx_data_capture_unit i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .system_reset_n(sys_rst_n), .serial_clock_line(sclk), .serial_data_line_n_i(line_n),
    .serial_data_line_n_o(line_o), .serial_data_line_n_oe(oe), .receive_select(sel),
    .data_out(dout), .size_out(sout), .commit_pulse(pulse));
  drx_sender_model i_sndr (.aclk(aclk), .line_n(line_n), .sclk(sclk), .pull(pull));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task summarize();
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    axr(a, v, r);
    chk(v, e);
  endtask : rdc
  task run(input drx_row_s w);
    int p0;
    p0 = pulses;
    i_sndr.frame(w.code, w.data, w.drv, st);
    if (w.ok) begin
      exp_d = w.data;
      exp_sz = w.code;
    end
    chk(st, w.st);
    chk(pulses - p0, w.ok);
    chk(dout, exp_d);
    chk(sout, exp_sz);
  endtask : run
  initial begin
    rows = '{'{3'h1, 32'h0000_00a5, 4'h4, 3'h3, 1'b1}, '{3'h2, 32'h0000_81c3, 4'h4, 3'h3, 1'b1},
      '{3'h3, 32'hc35a_0f96, 4'h4, 3'h3, 1'b1}, '{3'h3, 32'h1111_2222, 4'h0, 3'h1, 1'b0},
      '{3'h2, 32'h0000_3333, 4'h5, 3'h3, 1'b0}, '{3'h1, 32'h0000_0044, 4'h8, 3'h4, 1'b0},
      '{3'h0, 32'h0, 4'h0, 3'h5, 1'b0}, '{3'h4, 32'h0, 4'h0, 3'h5, 1'b0},
      '{3'h5, 32'h0, 4'h0, 3'h5, 1'b0}, '{3'h6, 32'h0, 4'h0, 3'h5, 1'b0},
      '{3'h7, 32'h0, 4'h0, 3'h0, 1'b0}, '{3'h1, 32'h0000_00a5, 4'h4, 3'h2, 1'b0}};
    {n_fail, compares, cyc, pulses} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    sys_rst_n = 1'b1;
    sel = 1'b1;
    exp_d = '0;
    exp_sz = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 11; i++) begin
      run(rows[i]);
    end
    // Three commits with no read in between
    rdc(`DRX_STAT_OFS, 32'h3);
    rdc(`DRX_DATA_OFS, 32'hc35a_0f96);
    rdc(`DRX_SIZE_OFS, 32'h3);
    rdc(`DRX_STAT_OFS, 32'h2);
    axw(`DRX_STAT_OFS, 32'h2, r);
    chk(r, `DRX_RESP_OKAY);
    rdc(`DRX_STAT_OFS, 32'h0);
    axr(8'h10, v, r);
    chk(r, `DRX_RESP_SLVERR);
    chk(v, 32'h0);
    axw(`DRX_DATA_OFS, 32'h1, r);
    chk(r, `DRX_RESP_SLVERR);
    sel <= 1'b0;
    run(rows[11]);
    sel <= 1'b1;
    axw(`DRX_CTRL_OFS, 32'h0, r);
    chk(r, `DRX_RESP_OKAY);
    run(rows[11]);
    axw(`DRX_CTRL_OFS, 32'h1, r);
    chk(r, `DRX_RESP_OKAY);
    rdc(`DRX_CTRL_OFS, 32'h1);
    // Bus reset clears the outputs and blinds the unit
    sys_rst_n <= 1'b0;
    repeat (6) @(posedge aclk);
    exp_d = '0;
    exp_sz = '0;
    chk(dout, 32'h0);
    chk(sout, 3'h0);
    run(rows[11]);
    sys_rst_n <= 1'b1;
    repeat (6) @(posedge aclk);
    run(rows[0]);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(dout, 32'h0);
    rdc(`DRX_CTRL_OFS, 32'h1);
    summarize();
  end
endmodule : tb_top
